// >>> design/dmacs_engine.v
// Seven-channel DMA engine: channel set-up registers, arbitration, offsets and event flags.
`include "dmacs_defines.vh"
// Functional notes
// RQ1: Software selects a channel first; per-channel accesses then target that channel.
// RQ2: Configuration holds function, endianness, full and mid-point interrupt enables.
// RQ3: With wrap on, offset returns to zero after a completed transfer.
// RQ4: Software programs base address pair before enabling the channel.
// RQ5: Software programs transfer length in bytes into the size pair.
// RQ6: Software zeroes the offset pair before enabling the channel.
// RQ7: Software sets the enable bit last to let the channel run.
// RQ8: Enable bit n turns channel n on; register resets to zero.
// RQ9: Bit 7 of enable and flag registers reads zero, ignores writes.
// RQ10: Full-length flag sets when offset equals size minus one.
// RQ11: Flags stay set until software clears them or reset.
// RQ12: Configuration bit 7 enables the full-length interrupt.
// RQ13: Mid-point flag sets at half size, or half plus one when odd.
// RQ14: Configuration bit 6 enables the mid-point interrupt.
// RQ15: Full-length flag register has channel n at bit n, resets zero.
// RQ16: Mid-point flag register has channel n at bit n, resets zero.
// RQ17: XRAM address is base plus offset; offset steps by one per byte.
// RQ18: Lowest-numbered requesting channel wins, chosen only at byte boundaries.
// RQ19: Size, base and offset writes are ignored while the channel transfers; code blocks them only while chan_busy marks its one-byte grant.
// RQ20: A flag of one means the event happened; zero means not.
// RQ21: Interrupt request rises when any set flag meets its enable.
module dmacs_engine (
    // Clock and reset
    input  wire        clock,
    input  wire        rstn,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    // Peripheral requests, one per channel
    input  wire [6:0]  periph_req,
    input  wire [7:0]  periph_data,
    // XRAM side
    output reg  [11:0] xram_addr,
    output wire        xram_valid,
    input  wire        xram_ready,
    output wire [7:0]  xram_data,
    // Status
    output reg  [6:0]  chan_busy,
    output wire        irq
);
    // ======================================================================
    // States
    localparam ST_IDLE = 2'b01;
    localparam ST_MOVE = 2'b10;
    // ======================================================================
    // Registers
    reg [2:0]  config_channel_select;
    reg [6:0]  channel_enable;
    reg [6:0]  full_length_flags;
    reg [6:0]  midpoint_flags;
    reg [7:0]  channel_configuration [0:6];
    reg [6:0]  channel_wrap_mode;
    reg [11:0] xram_base_address [0:6];
    reg [9:0]  transfer_size_bytes [0:6];
    reg [9:0]  address_offset_counter [0:6];
    reg [1:0]  state;
    reg [2:0]  active;
    reg [6:0]  req_s1;
    reg [6:0]  req_s2;
    wire       buf_ready;
    wire [6:0] full_hit;
    wire [6:0] half_hit;
    wire [6:0] full_ie;
    wire [6:0] half_ie;
    wire [6:0] eligible;
    wire       moving;
    // Lowest set bit wins; decoding shared by grant and busy logic.
    function [2:0] dmacs_pick;
        input [6:0] v;
        integer k;
        begin
            dmacs_pick = 3'd0;
            for (k = 6; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    dmacs_pick = k[2:0];
                end
            end
        end
    endfunction
    function [6:0] dmacs_onehot;
        input [2:0] c;
        begin
            dmacs_onehot = 7'h01 << c;
        end
    endfunction
    // ======================================================================
    // Request synchronisers
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            req_s1 <= 7'h00;
            req_s2 <= 7'h00;
        end else begin
            req_s1 <= periph_req;
            req_s2 <= req_s1;
        end
    end
    // ======================================================================
    // Per-channel decode
    genvar g;
    generate
        for (g = 0; g < `DMACS_NCHAN; g = g + 1) begin : g_chan
            wire [9:0] sz = transfer_size_bytes[g];
            assign full_hit[g] = (address_offset_counter[g] == sz - `DMACS_ONE_CNT); // RQ10
            assign half_hit[g] = (address_offset_counter[g] == ((sz >> 1) + {9'h000, sz[0]})); // RQ13
            assign full_ie[g]  = channel_configuration[g][`DMACS_CF_FULL_IE]; // RQ12
            assign half_ie[g]  = channel_configuration[g][`DMACS_CF_HALF_IE]; // RQ14
            // A channel holding an unserviced full flag or stalled waits for software.
            assign eligible[g] = channel_enable[g] & req_s2[g] & ~full_length_flags[g] // RQ8
                               & ~channel_configuration[g][`DMACS_CF_STALL];
        end
    endgenerate
    assign irq    = |((full_length_flags & full_ie) | (midpoint_flags & half_ie)); // RQ21
    assign moving = (state == ST_MOVE) && buf_ready;
    // ======================================================================
    // Arbiter and transfer sequencer
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state     <= ST_IDLE;
            active    <= 3'd0;
            chan_busy <= 7'h00;
            xram_addr <= 12'h000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (|eligible) begin
                        active    <= dmacs_pick(eligible); // RQ18
                        chan_busy <= dmacs_onehot(dmacs_pick(eligible));
                        xram_addr <= xram_base_address[dmacs_pick(eligible)]
                                   + {2'b00, address_offset_counter[dmacs_pick(eligible)]}; // RQ17
                        state     <= ST_MOVE;
                    end
                end
                ST_MOVE: begin
                    if (buf_ready) begin
                        chan_busy <= 7'h00;
                        state     <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
    dmacs_skid u_buf (
        .clock     (clock),
        .rstn      (rstn),
        .in_valid  (state == ST_MOVE),
        .in_ready  (buf_ready),
        .in_data   (periph_data),
        .out_valid (xram_valid),
        .out_ready (xram_ready),
        .out_data  (xram_data)
    );
    // ======================================================================
    // Register writes, flags and offsets
    integer i;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            config_channel_select <= 3'd0;
            channel_enable        <= 7'h00;
            full_length_flags     <= 7'h00;
            midpoint_flags        <= 7'h00;
            channel_wrap_mode     <= 7'h00;
            for (i = 0; i < `DMACS_NCHAN; i = i + 1) begin
                channel_configuration[i]  <= `DMACS_REG_RESET;
                xram_base_address[i]      <= 12'h000;
                transfer_size_bytes[i]    <= `DMACS_ZERO_CNT;
                address_offset_counter[i] <= `DMACS_ZERO_CNT;
            end
        end else begin
            // Software writes first so that a same-cycle hardware set wins below.
            if (reg_wr) begin
                case (reg_addr)
                    `DMACS_ADDR_SELECT:     config_channel_select <= reg_wdata[2:0]; // RQ1
                    `DMACS_ADDR_ENABLE:     channel_enable <= reg_wdata[6:0]; // RQ9
                    `DMACS_ADDR_FULL_FLAGS: full_length_flags <= reg_wdata[6:0]; // RQ15
                    `DMACS_ADDR_HALF_FLAGS: midpoint_flags <= reg_wdata[6:0]; // RQ16
                    default: begin
                    end
                endcase
                // Select value 7 is invalid and reaches no channel.
                if (config_channel_select < `DMACS_NCHAN) begin
                    case (reg_addr)
                        `DMACS_ADDR_CHAN_CF:   channel_configuration[config_channel_select] <= reg_wdata; // RQ2
                        `DMACS_ADDR_WRAP_MODE: channel_wrap_mode[config_channel_select] <= reg_wdata[`DMACS_WRAP_BIT];
                        default: begin
                        end
                    endcase
                    if (!chan_busy[config_channel_select]) begin // RQ19
                        case (reg_addr)
                            `DMACS_ADDR_BASE_H: xram_base_address[config_channel_select][11:8] <= reg_wdata[3:0];
                            `DMACS_ADDR_BASE_L: xram_base_address[config_channel_select][7:0] <= reg_wdata;
                            `DMACS_ADDR_SIZE_H: transfer_size_bytes[config_channel_select][9:8] <= reg_wdata[1:0];
                            `DMACS_ADDR_SIZE_L: transfer_size_bytes[config_channel_select][7:0] <= reg_wdata;
                            `DMACS_ADDR_OFFS_H: address_offset_counter[config_channel_select][9:8] <= reg_wdata[1:0];
                            `DMACS_ADDR_OFFS_L: address_offset_counter[config_channel_select][7:0] <= reg_wdata;
                            default: begin
                            end
                        endcase
                    end
                end
            end
            // Hardware only ever sets flags here, never clears them; clearing is left to software writes.
            if (moving) begin
                if (full_hit[active]) begin
                    full_length_flags[active] <= 1'b1; // RQ11
                    if (channel_wrap_mode[active]) begin
                        address_offset_counter[active] <= `DMACS_ZERO_CNT; // RQ3
                    end
                end else begin
                    address_offset_counter[active] <= address_offset_counter[active] + `DMACS_ONE_CNT; // RQ17
                end
                if (half_hit[active]) begin
                    midpoint_flags[active] <= 1'b1; // RQ20
                end
            end
        end
    end
    // ======================================================================
    // Read mux
    always @* begin
        reg_rdata = 8'h00;
        case (reg_addr)
            `DMACS_ADDR_SELECT:     reg_rdata = {5'h00, config_channel_select};
            `DMACS_ADDR_ENABLE:     reg_rdata = {1'b0, channel_enable}; // RQ9
            `DMACS_ADDR_FULL_FLAGS: reg_rdata = {1'b0, full_length_flags};
            `DMACS_ADDR_HALF_FLAGS: reg_rdata = {1'b0, midpoint_flags};
            `DMACS_ADDR_BUSY:       reg_rdata = {1'b0, chan_busy};
            default: begin
                if (config_channel_select < `DMACS_NCHAN) begin
                    case (reg_addr)
                        `DMACS_ADDR_CHAN_CF:   reg_rdata = channel_configuration[config_channel_select];
                        `DMACS_ADDR_WRAP_MODE: reg_rdata = {7'h00, channel_wrap_mode[config_channel_select]};
                        `DMACS_ADDR_BASE_H:    reg_rdata = {4'h0, xram_base_address[config_channel_select][11:8]};
                        `DMACS_ADDR_BASE_L:    reg_rdata = xram_base_address[config_channel_select][7:0];
                        `DMACS_ADDR_SIZE_H:    reg_rdata = {6'h00, transfer_size_bytes[config_channel_select][9:8]};
                        `DMACS_ADDR_SIZE_L:    reg_rdata = transfer_size_bytes[config_channel_select][7:0];
                        `DMACS_ADDR_OFFS_H:    reg_rdata = {6'h00, address_offset_counter[config_channel_select][9:8]};
                        `DMACS_ADDR_OFFS_L:    reg_rdata = address_offset_counter[config_channel_select][7:0];
                        default:               reg_rdata = 8'h00;
                    endcase
                end
            end
        endcase
    end
endmodule

// >>> design/dmacs_skid.v
// Two-entry buffer with valid and ready on both sides for the transfer data path.
`include "dmacs_defines.vh"
module dmacs_skid (
    // Clock and reset
    input  wire        clock,
    input  wire        rstn,
    // Filling side
    input  wire        in_valid,
    output wire        in_ready,
    input  wire [7:0]  in_data,
    // Draining side
    output wire        out_valid,
    input  wire        out_ready,
    output reg  [7:0]  out_data
);
    // ======================================================================
    // Storage
    reg [7:0] spare;
    reg       full0;
    reg       full1;
    assign in_ready  = ~full1;
    assign out_valid = full0;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            full0    <= 1'b0;
            full1    <= 1'b0;
            out_data <= 8'h00;
            spare    <= 8'h00;
        end else begin
            if (full0 && out_ready) begin
                if (full1) begin
                    // The filling side sees in_ready low here, so nothing may be taken in.
                    out_data <= spare;
                    full1    <= 1'b0;
                end else if (in_valid) begin
                    out_data <= in_data;
                end else begin
                    full0 <= 1'b0;
                end
            end else if (in_valid && !full1) begin
                if (!full0) begin
                    out_data <= in_data;
                    full0    <= 1'b1;
                end else begin
                    spare <= in_data;
                    full1 <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> dv/dmacs_engine_props.sv
// Concurrent checks on the DMA engine's register port and transfer outputs.
`include "dmacs_defines.vh"
module dmacs_engine_props (
    // Clock and reset
    input wire        clock,
    input wire        rstn,
    // Register port
    input wire [7:0]  reg_addr,
    input wire        reg_wr,
    input wire [7:0]  reg_wdata,
    input wire [7:0]  reg_rdata,
    // Transfer side
    input wire [6:0]  periph_req,
    input wire [7:0]  periph_data,
    input wire [11:0] xram_addr,
    input wire        xram_valid,
    input wire        xram_ready,
    input wire [7:0]  xram_data,
    input wire [6:0]  chan_busy,
    input wire        irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // ==========================================================================
    // Register port
    property p_bit7_zero;
        (reg_addr >= `DMACS_ADDR_ENABLE && reg_addr <= `DMACS_ADDR_HALF_FLAGS) |-> !reg_rdata[7];
    endproperty
    a_bit7_zero: assert property (p_bit7_zero) else $error("unused bit seen high");
    property p_enable_write;
        reg_wr && reg_addr == `DMACS_ADDR_ENABLE ##1 reg_addr == `DMACS_ADDR_ENABLE
            |-> reg_rdata == ($past(reg_wdata) & 8'h7f);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write lost");
    property p_full_write;
        reg_wr && reg_addr == `DMACS_ADDR_FULL_FLAGS && chan_busy == 7'h00 ##1 reg_addr == `DMACS_ADDR_FULL_FLAGS
            |-> reg_rdata == ($past(reg_wdata) & 8'h7f);
    endproperty
    a_full_write: assert property (p_full_write) else $error("full flag write lost");
    property p_half_write;
        reg_wr && reg_addr == `DMACS_ADDR_HALF_FLAGS && chan_busy == 7'h00 ##1 reg_addr == `DMACS_ADDR_HALF_FLAGS
            |-> reg_rdata == ($past(reg_wdata) & 8'h7f);
    endproperty
    a_half_write: assert property (p_half_write) else $error("mid flag write lost");
    // A flag may only fall through a software write; the engine never drops one.
    property p_full_sticky;
        !reg_wr && reg_addr == `DMACS_ADDR_FULL_FLAGS ##1 reg_addr == `DMACS_ADDR_FULL_FLAGS
            |-> ($past(reg_rdata) & ~reg_rdata) == 8'h00;
    endproperty
    a_full_sticky: assert property (p_full_sticky) else $error("full flag cleared itself");
    property p_half_sticky;
        !reg_wr && reg_addr == `DMACS_ADDR_HALF_FLAGS ##1 reg_addr == `DMACS_ADDR_HALF_FLAGS
            |-> ($past(reg_rdata) & ~reg_rdata) == 8'h00;
    endproperty
    a_half_sticky: assert property (p_half_sticky) else $error("mid flag cleared itself");
    // ==========================================================================
    // Transfer side
    property p_busy_onehot;
        $onehot0(chan_busy);
    endproperty
    a_busy_onehot: assert property (p_busy_onehot) else $error("two channels granted");
    property p_busy_short;
        (chan_busy != 7'h00) && !xram_valid |=> chan_busy == 7'h00 && xram_valid;
    endproperty
    a_busy_short: assert property (p_busy_short) else $error("grant not one byte");
    property p_hold;
        xram_valid && !xram_ready |=> xram_valid && $stable(xram_data);
    endproperty
    a_hold: assert property (p_hold) else $error("buffered byte dropped");
endmodule
bind dmacs_engine dmacs_engine_props u_props (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .periph_req(periph_req), .periph_data(periph_data),
    .xram_addr(xram_addr), .xram_valid(xram_valid), .xram_ready(xram_ready), .xram_data(xram_data),
    .chan_busy(chan_busy), .irq(irq));

// >>> dv/dmacs_engine_tb.sv
// Self-checking bench for the DMA engine: registers, transfers, flags, wrap and priority.
`include "dmacs_defines.vh"
module dmacs_engine_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [6:0]  periph_req = 7'h00;
    logic [7:0]  periph_data = 8'h00;
    logic        slow = 1'b0;
    wire  [7:0]  reg_rdata;
    wire  [11:0] xram_addr;
    wire         xram_valid;
    wire         xram_ready;
    wire  [7:0]  xram_data;
    wire  [6:0]  chan_busy;
    wire         irq;
    int          err_total = 0;
    int          n_checks = 0;
    int          i;
    always #20 clock = ~clock;
    dmacs_engine DUT (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .periph_req(periph_req), .periph_data(periph_data), .xram_addr(xram_addr),
        .xram_valid(xram_valid), .xram_ready(xram_ready), .xram_data(xram_data), .chan_busy(chan_busy), .irq(irq));
    dmacs_xram_model u_xram (.clock(clock), .rstn(rstn), .xram_addr(xram_addr), .xram_valid(xram_valid),
        .xram_data(xram_data), .chan_busy(chan_busy), .xram_ready(xram_ready), .slow(slow));
    // ==========================================================================
    // Tasks
    task stop_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task check(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        reg_addr = a;
        #5 check({4'h0, reg_rdata}, {4'h0, exp});
    endtask
    task setup(input logic [7:0] ch, input logic [7:0] cf, input logic [7:0] wrap, input logic [11:0] base,
               input logic [9:0] size);
        wr(`DMACS_ADDR_SELECT, ch);
        wr(`DMACS_ADDR_CHAN_CF, cf);
        wr(`DMACS_ADDR_WRAP_MODE, wrap);
        wr(`DMACS_ADDR_BASE_H, {4'h0, base[11:8]});
        wr(`DMACS_ADDR_BASE_L, base[7:0]);
        wr(`DMACS_ADDR_SIZE_H, {6'h00, size[9:8]});
        wr(`DMACS_ADDR_SIZE_L, size[7:0]);
        wr(`DMACS_ADDR_OFFS_H, 8'h00);
        wr(`DMACS_ADDR_OFFS_L, 8'h00);
    endtask
    // Waiting on past the last byte proves the channel really stopped at its flag.
    task wait_data(input int n);
        for (i = 0; i < 3000 && u_xram.n_data < n; i++)
            @(negedge clock);
        if (u_xram.n_data < n) begin
            err_total++;
            stop_test();
        end
        repeat (40) @(negedge clock);
        check(12'(u_xram.n_data), 12'(n));
    endtask
    task log_chk(input int k, input logic [11:0] a, input logic [7:0] d);
        check(u_xram.addr_log[k], a);
        check({4'h0, u_xram.data_log[k]}, {4'h0, d});
    endtask
    // ==========================================================================
    // Sequence
    initial begin
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        rd(8'h00, 8'h00);
        for (int r = 0; r < 3; r++) begin
            rd(`DMACS_ADDR_ENABLE + 8'(r), 8'h00);
            wr(`DMACS_ADDR_ENABLE + 8'(r), 8'hff);
            rd(`DMACS_ADDR_ENABLE + 8'(r), 8'h7f);
            wr(`DMACS_ADDR_ENABLE + 8'(r), 8'h00);
        end
        setup(8'h01, 8'h00, 8'h00, 12'h200, 10'h003);
        setup(8'h02, 8'hc0, 8'h00, 12'h100, 10'h005);
        wr(`DMACS_ADDR_ENABLE, 8'h06);
        slow = 1'b1;
        periph_data = 8'ha5;
        periph_req = 7'h06;
        wait_data(8);
        periph_req = 7'h00;
        for (int k = 0; k < 3; k++)
            log_chk(k, 12'h200 + 12'(k), 8'ha5);
        for (int k = 0; k < 5; k++)
            log_chk(k + 3, 12'h100 + 12'(k), 8'ha5);
        rd(`DMACS_ADDR_FULL_FLAGS, 8'h06);
        rd(`DMACS_ADDR_HALF_FLAGS, 8'h06);
        check({11'h000, irq}, 12'h001);
        wr(`DMACS_ADDR_FULL_FLAGS, 8'h00);
        check({11'h000, irq}, 12'h001);
        wr(`DMACS_ADDR_HALF_FLAGS, 8'h02);
        rd(`DMACS_ADDR_HALF_FLAGS, 8'h02);
        check({11'h000, irq}, 12'h000);
        slow = 1'b0;
        setup(8'h00, 8'h00, 8'h01, 12'h020, 10'h002);
        wr(`DMACS_ADDR_ENABLE, 8'h01);
        periph_data = 8'h3c;
        periph_req = 7'h01;
        wait_data(10);
        rd(`DMACS_ADDR_FULL_FLAGS, 8'h01);
        check({11'h000, irq}, 12'h000);
        wr(`DMACS_ADDR_FULL_FLAGS, 8'h00);
        wait_data(12);
        periph_req = 7'h00;
        log_chk(8, 12'h020, 8'h3c);
        log_chk(9, 12'h021, 8'h3c);
        log_chk(10, 12'h020, 8'h3c);
        log_chk(11, 12'h021, 8'h3c);
        stop_test();
    end
endmodule

// >>> dv/dmacs_xram_model.sv
// XRAM sink model that accepts buffered bytes and logs granted addresses.
module dmacs_xram_model (
    // Clock and reset
    input  wire        clock,
    input  wire        rstn,
    // Engine side
    input  wire [11:0] xram_addr,
    input  wire        xram_valid,
    input  wire [7:0]  xram_data,
    input  wire [6:0]  chan_busy,
    output wire        xram_ready,
    // Bench control
    input  wire        slow
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0]  pace;
    logic        busy_q;
    logic [11:0] addr_log [0:15];
    logic [7:0]  data_log [0:15];
    int          n_addr;
    int          n_data;
    // Slow mode accepts one cycle in four so the two-entry buffer fills and refuses.
    assign xram_ready = !slow || pace == 2'h3;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pace <= 2'h0;
            busy_q <= 1'b0;
            n_addr <= 0;
            n_data <= 0;
        end else begin
            pace <= pace + 2'h1;
            busy_q <= |chan_busy;
            if ((|chan_busy) && !busy_q) begin
                addr_log[n_addr[3:0]] <= xram_addr;
                n_addr <= n_addr + 1;
            end
            if (xram_valid && xram_ready) begin
                data_log[n_data[3:0]] <= xram_data;
                n_data <= n_data + 1;
            end
        end
    end
endmodule

// >>> shared/dmacs_defines.vh
// Register offsets, field positions and widths for the DMA channel set-up block.
`ifndef DMACS_DEFINES_VH
`define DMACS_DEFINES_VH
// ==========================================================================
// Register offsets
`define DMACS_ADDR_CHAN_CF     8'hc9
`define DMACS_ADDR_SELECT      8'hd1
`define DMACS_ADDR_ENABLE      8'hd2
`define DMACS_ADDR_FULL_FLAGS  8'hd3
`define DMACS_ADDR_HALF_FLAGS  8'hd4
`define DMACS_ADDR_BUSY        8'hd5
`define DMACS_ADDR_WRAP_MODE   8'hd6
`define DMACS_ADDR_BASE_H      8'hd7
`define DMACS_ADDR_BASE_L      8'hd8
`define DMACS_ADDR_SIZE_H      8'hd9
`define DMACS_ADDR_SIZE_L      8'hda
`define DMACS_ADDR_OFFS_H      8'hdb
`define DMACS_ADDR_OFFS_L      8'hdc
// ==========================================================================
// Fields and widths
`define DMACS_NCHAN            7
`define DMACS_CF_FULL_IE       7
`define DMACS_CF_HALF_IE       6
`define DMACS_CF_STALL         5
`define DMACS_CF_MASK          8'hff
`define DMACS_SEL_MASK         8'h07
`define DMACS_WRAP_BIT         0
`define DMACS_BASE_W           12
`define DMACS_CNT_W            10
`define DMACS_REG_RESET        8'h00
`define DMACS_ZERO_CNT         10'h000
`define DMACS_ONE_CNT          10'h001
`define DMACS_CHAN_MASK        7'h7f
`endif
